/* rtl/sirqc_top.sv */
`timescale 1ns/1ns
// Summary of operation
// - The start frame lasts 4, 6 or 8 clocks for width codes 00, 01, 10, and 4 after reset.
// - The polling bit picks continuous operation when clear and quiet operation when set.
// - In recovery the line is driven high when the drive bit is clear, released when set.
// - Each of the sixteen lines has its own bit selecting edge (0) or level (1) handling.
// - A level-handled line signalled in the serial stream sets its status bit.
// - Writing 1 to a status bit clears it and re-arms that line for reporting.
// - A line set for edge handling never sets its status bit.
// - Mode, edge and status bits clear on link reset, global reset and power-on reset.
// - Bits 7 to 4 of the mode register are read-only zero.
// - Mode register sits at window 0x48 and config 0xE0 over one storage.
// - Edge register sits at window 0x4A and config 0xE2 over one storage.
// - Status register sits at window 0x4C and config 0xE4 over one storage.
module sirqc_top
	import sirqc_pkg::*;
(
	// clock and resets
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic perst_b_i,
	input wire logic global_reset_input_i,
	// memory window register port
	input wire sirqc_req_t mem_req_i,
	output sirqc_rsp_t mem_rsp_o,
	// configuration space register port
	input wire sirqc_req_t cfg_req_i,
	output sirqc_rsp_t cfg_rsp_o,
	// shared serial interrupt line
	input wire logic serirq_i,
	output logic serirq_o,
	output logic serirq_oe_o
);

	sirqc_state_t s_r;
	sirqc_state_t s_nxt;
	logic sync_clr;
	logic line_low;
	logic [15:0] set_mask;
	logic [15:0] clr_mask;
	logic [3:0] start_w;
	logic [3:0] stop_w;

	always_comb begin
		sirqc_req_t rq;
		logic [7:0] a_mode;
		logic [7:0] a_edge;
		logic [7:0] a_stat;
		sirqc_rsp_t rs;
		rq = mem_req_i;
		a_mode = SIRQC_MODE_MEM;
		a_edge = SIRQC_EDGE_MEM;
		a_stat = SIRQC_STAT_MEM;
		rs = '0;
		s_nxt = s_r;
		// the first flops feed only the second ones
		s_nxt.sync1 = {serirq_i, global_reset_input_i, perst_b_i};
		s_nxt.sync2 = s_r.sync1;
		sync_clr = s_r.sync2[1] | ~s_r.sync2[0];
		line_low = ~s_r.sync2[2];
		clr_mask = '0;
		set_mask = '0;
		// reserved width code falls back to the shortest start frame
		case (s_r.mode[SIRQC_WIDTH_LSB +: 2])
			SIRQC_W_CODE6: start_w = SIRQC_START_W6;
			SIRQC_W_CODE8: start_w = SIRQC_START_W8;
			default: start_w = SIRQC_START_W4;
		endcase
		stop_w = s_r.mode[SIRQC_POLL_BIT] ? SIRQC_STOP_QUIET : SIRQC_STOP_CONT;

		// config port first so the memory window wins a same-cycle mode or edge write
		for (int p = 1; p >= 0; p--) begin
			if (p == 1) begin
				rq = cfg_req_i;
				a_mode = SIRQC_MODE_CFG;
				a_edge = SIRQC_EDGE_CFG;
				a_stat = SIRQC_STAT_CFG;
			end else begin
				rq = mem_req_i;
				a_mode = SIRQC_MODE_MEM;
				a_edge = SIRQC_EDGE_MEM;
				a_stat = SIRQC_STAT_MEM;
			end
			rs = '0;
			rs.ack = rq.rd | rq.wr;
			if (rq.addr == a_mode) begin
				if (rq.wr && rq.be[0]) begin
					s_nxt.mode = rq.wdata[3:0] & SIRQC_MODE_MASK;
				end
				rs.rdata = {12'h000, s_r.mode};
			end else if (rq.addr == a_edge) begin
				if (rq.wr && rq.be[0]) begin
					s_nxt.edge_ctl[7:0] = rq.wdata[7:0];
				end
				if (rq.wr && rq.be[1]) begin
					s_nxt.edge_ctl[15:8] = rq.wdata[15:8];
				end
				rs.rdata = s_r.edge_ctl;
			end else if (rq.addr == a_stat) begin
				if (rq.wr) begin
					// ones clear, zeros leave bits alone
					clr_mask = clr_mask | (rq.wdata & {{8{rq.be[1]}}, {8{rq.be[0]}}});
				end
				rs.rdata = s_r.stat;
			end
			if (!rq.rd) begin
				rs.rdata = '0;
			end
			if (p == 1) begin
				s_nxt.cfg_rsp = rs;
			end else begin
				s_nxt.mem_rsp = rs;
			end
		end

		// frame sequencer
		case (s_r.fsm)
			SIRQC_IDLE: begin
				s_nxt.cnt = '0;
				if (!s_r.mode[SIRQC_POLL_BIT] || line_low) begin
					s_nxt.fsm = SIRQC_START;
				end
			end
			SIRQC_START: begin
				s_nxt.cnt = s_r.cnt + 4'h1;
				if (s_r.cnt == start_w - 4'h1) begin
					s_nxt.fsm = SIRQC_SREC;
					s_nxt.cnt = '0;
				end
			end
			SIRQC_SREC: s_nxt.fsm = SIRQC_STURN;
			SIRQC_STURN: begin
				s_nxt.fsm = SIRQC_SLOT;
				s_nxt.slot = '0;
				s_nxt.cnt = '0;
			end
			SIRQC_SLOT: begin
				// sample phase is the first clock of each slot
				if (s_r.cnt == '0 && line_low && s_r.edge_ctl[s_r.slot]) begin
					set_mask[s_r.slot] = 1'b1;
				end
				s_nxt.cnt = s_r.cnt + 4'h1;
				if (s_r.cnt == SIRQC_SLOT_LAST_PH) begin
					s_nxt.cnt = '0;
					s_nxt.slot = s_r.slot + 4'h1;
					if (s_r.slot == SIRQC_LAST_SLOT) begin
						s_nxt.fsm = SIRQC_STOP;
					end
				end
			end
			SIRQC_STOP: begin
				s_nxt.cnt = s_r.cnt + 4'h1;
				if (s_r.cnt == stop_w - 4'h1) begin
					s_nxt.fsm = SIRQC_PREC;
					s_nxt.cnt = '0;
				end
			end
			SIRQC_PREC: s_nxt.fsm = SIRQC_PTURN;
			SIRQC_PTURN: s_nxt.fsm = SIRQC_IDLE;
			default: s_nxt.fsm = SIRQC_IDLE;
		endcase

		// a set in the same cycle as a clear is kept
		s_nxt.stat = (s_r.stat & ~clr_mask) | set_mask;

		if (sync_clr) begin
			s_nxt.mode = '0;
			s_nxt.edge_ctl = '0;
			s_nxt.stat = '0;
			s_nxt.fsm = SIRQC_IDLE;
			s_nxt.cnt = '0;
		end

		// pin drive follows the next state so it leaves a flop
		s_nxt.pin_out = 1'b1;
		s_nxt.pin_oe = 1'b0;
		case (s_nxt.fsm)
			SIRQC_START, SIRQC_STOP: begin
				s_nxt.pin_out = 1'b0;
				s_nxt.pin_oe = 1'b1;
			end
			SIRQC_SREC, SIRQC_PREC: s_nxt.pin_oe = ~s_nxt.mode[SIRQC_DRIVE_BIT];
			default: s_nxt.pin_oe = 1'b0;
		endcase
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			// line bit idles high, else a false request shows right after reset
			s_r <= '{sync1: 3'h5, sync2: 3'h5, fsm: SIRQC_IDLE, pin_out: 1'b1, default: '0};
		end else begin
			s_r <= s_nxt;
		end
	end

	assign mem_rsp_o = s_r.mem_rsp;
	assign cfg_rsp_o = s_r.cfg_rsp;
	assign serirq_o = s_r.pin_out;
	assign serirq_oe_o = s_r.pin_oe;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_b_i);

	property p_start_four;
		($rose(s_r.fsm == SIRQC_START) && s_r.mode[3:2] == SIRQC_W_CODE4 && !sync_clr)
			|-> (s_r.fsm == SIRQC_START)[*4] ##1 (s_r.fsm == SIRQC_SREC);
	endproperty
	a_start_four: assert property (p_start_four) else $error("start frame not 4 clocks");

	property p_start_six;
		($rose(s_r.fsm == SIRQC_START) && s_r.mode[3:2] == SIRQC_W_CODE6 && !sync_clr)
			|-> (s_r.fsm == SIRQC_START)[*6] ##1 (s_r.fsm == SIRQC_SREC);
	endproperty
	a_start_six: assert property (p_start_six) else $error("start frame not 6 clocks");

	property p_quiet_wait;
		(s_r.fsm == SIRQC_IDLE && s_r.mode[SIRQC_POLL_BIT] && !line_low && !sync_clr)
			|=> (s_r.fsm == SIRQC_IDLE);
	endproperty
	a_quiet_wait: assert property (p_quiet_wait) else $error("quiet mode started a frame");

	property p_cont_go;
		(s_r.fsm == SIRQC_IDLE && !s_r.mode[SIRQC_POLL_BIT] && !sync_clr)
			|=> (s_r.fsm == SIRQC_START) && !serirq_o && serirq_oe_o;
	endproperty
	a_cont_go: assert property (p_cont_go) else $error("continuous mode idled");

	property p_recov_drive;
		(s_r.fsm == SIRQC_SREC || s_r.fsm == SIRQC_PREC)
			|-> serirq_o && (serirq_oe_o == !s_r.mode[SIRQC_DRIVE_BIT]);
	endproperty
	a_recov_drive: assert property (p_recov_drive) else $error("recovery drive wrong");

	property p_level_set;
		(set_mask != SIRQC_ZERO16 && !sync_clr) |=> ((s_r.stat & $past(set_mask)) == $past(set_mask));
	endproperty
	a_level_set: assert property (p_level_set) else $error("level line not latched");

	property p_edge_quiet;
		!$past(sync_clr) |-> ((s_r.stat & ~$past(s_r.stat) & ~$past(s_r.edge_ctl)) == SIRQC_ZERO16);
	endproperty
	a_edge_quiet: assert property (p_edge_quiet) else $error("edge line set status");

	property p_w1c;
		(clr_mask != SIRQC_ZERO16 && set_mask == SIRQC_ZERO16) |=> ((s_r.stat & $past(clr_mask)) == SIRQC_ZERO16);
	endproperty
	a_w1c: assert property (p_w1c) else $error("status not cleared by one");

	property p_keep_others;
		!$past(sync_clr)
			|-> (((s_r.stat ^ $past(s_r.stat)) & ~($past(set_mask) | $past(clr_mask))) == SIRQC_ZERO16);
	endproperty
	a_keep_others: assert property (p_keep_others) else $error("status bit changed alone");

	property p_mode_read;
		(mem_req_i.rd && mem_req_i.addr == SIRQC_MODE_MEM)
			|=> mem_rsp_o.ack && (mem_rsp_o.rdata[15:4] == 12'h000)
			&& (mem_rsp_o.rdata[3:0] == $past(s_r.mode));
	endproperty
	a_mode_read: assert property (p_mode_read) else $error("mode upper bits not zero");

	property p_mode_alias;
		(cfg_req_i.wr && cfg_req_i.be[0] && cfg_req_i.addr == SIRQC_MODE_CFG && !mem_req_i.wr && !sync_clr)
			|=> (s_r.mode == $past(cfg_req_i.wdata[3:0]));
	endproperty
	a_mode_alias: assert property (p_mode_alias) else $error("config mode write lost");

	property p_clear_all;
		sync_clr |=> (s_r.mode == 4'h0) && (s_r.edge_ctl == SIRQC_ZERO16) && (s_r.stat == SIRQC_ZERO16);
	endproperty
	a_clear_all: assert property (p_clear_all) else $error("reset left bits set");

	property p_start_eight;
		($rose(s_r.fsm == SIRQC_START) && s_r.mode[3:2] == SIRQC_W_CODE8 && !sync_clr)
			|-> (s_r.fsm == SIRQC_START)[*8] ##1 (s_r.fsm == SIRQC_SREC);
	endproperty
	a_start_eight: assert property (p_start_eight) else $error("start frame not 8 clocks");

	property p_edge_alias;
		(cfg_req_i.wr && cfg_req_i.be == 2'h3 && cfg_req_i.addr == SIRQC_EDGE_CFG
			&& !mem_req_i.wr && !sync_clr) |=> (s_r.edge_ctl == $past(cfg_req_i.wdata));
	endproperty
	a_edge_alias: assert property (p_edge_alias) else $error("config edge write lost");

	property p_stat_read;
		(cfg_req_i.rd && cfg_req_i.addr == SIRQC_STAT_CFG)
			|=> cfg_rsp_o.ack && (cfg_rsp_o.rdata == $past(s_r.stat));
	endproperty
	a_stat_read: assert property (p_stat_read) else $error("config status view differs");

	property p_zero_write;
		(mem_req_i.wr && mem_req_i.addr == SIRQC_STAT_MEM && mem_req_i.wdata == SIRQC_ZERO16
			&& !cfg_req_i.wr && !sync_clr) |=> ((s_r.stat & $past(s_r.stat)) == $past(s_r.stat));
	endproperty
	a_zero_write: assert property (p_zero_write) else $error("zero write cleared status");

	property p_slot_release;
		(s_r.fsm == SIRQC_STURN || s_r.fsm == SIRQC_SLOT) |-> !serirq_oe_o;
	endproperty
	a_slot_release: assert property (p_slot_release) else $error("line driven in slots");

	c_level_seen: cover property (set_mask != SIRQC_ZERO16);
	c_quiet_frame: cover property (s_r.mode[SIRQC_POLL_BIT] && $rose(s_r.fsm == SIRQC_START));
	c_set_clear: cover property ((set_mask & clr_mask) != SIRQC_ZERO16);
	c_wide_start: cover property (s_r.mode[3:2] == SIRQC_W_CODE8 && s_r.fsm == SIRQC_SREC);
	c_sync_clear: cover property ($fell(sync_clr));

endmodule

/* rtl/sirqc_pkg.sv */
package sirqc_pkg;

	// register offsets, memory window and configuration space views
	localparam logic [7:0] SIRQC_MODE_MEM = 8'h48;
	localparam logic [7:0] SIRQC_EDGE_MEM = 8'h4A;
	localparam logic [7:0] SIRQC_STAT_MEM = 8'h4C;
	localparam logic [7:0] SIRQC_MODE_CFG = 8'hE0;
	localparam logic [7:0] SIRQC_EDGE_CFG = 8'hE2;
	localparam logic [7:0] SIRQC_STAT_CFG = 8'hE4;

	// mode control field layout
	localparam int SIRQC_DRIVE_BIT = 0;
	localparam int SIRQC_POLL_BIT = 1;
	localparam int SIRQC_WIDTH_LSB = 2;
	localparam logic [3:0] SIRQC_MODE_MASK = 4'h0F;
	localparam logic [15:0] SIRQC_ZERO16 = 16'h0000;

	// start frame width codes and lengths in clocks
	localparam logic [1:0] SIRQC_W_CODE4 = 2'h0;
	localparam logic [1:0] SIRQC_W_CODE6 = 2'h1;
	localparam logic [1:0] SIRQC_W_CODE8 = 2'h2;
	localparam logic [3:0] SIRQC_START_W4 = 4'h4;
	localparam logic [3:0] SIRQC_START_W6 = 4'h6;
	localparam logic [3:0] SIRQC_START_W8 = 4'h8;

	// stop frame lengths select the next polling style for peripherals
	localparam logic [3:0] SIRQC_STOP_QUIET = 4'h2;
	localparam logic [3:0] SIRQC_STOP_CONT = 4'h3;
	localparam logic [3:0] SIRQC_SLOT_LAST_PH = 4'h2;
	localparam logic [3:0] SIRQC_LAST_SLOT = 4'hF;
	localparam int SIRQC_NUM_IRQ = 16;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [1:0] be;
		logic [15:0] wdata;
	} sirqc_req_t;

	typedef struct packed {
		logic ack;
		logic [15:0] rdata;
	} sirqc_rsp_t;

	typedef enum logic [7:0] {
		SIRQC_IDLE = 8'b0000_0001,
		SIRQC_START = 8'b0000_0010,
		SIRQC_SREC = 8'b0000_0100,
		SIRQC_STURN = 8'b0000_1000,
		SIRQC_SLOT = 8'b0001_0000,
		SIRQC_STOP = 8'b0010_0000,
		SIRQC_PREC = 8'b0100_0000,
		SIRQC_PTURN = 8'b1000_0000
	} sirqc_fsm_t;

	typedef struct packed {
		logic [2:0] sync1;
		logic [2:0] sync2;
		logic [3:0] mode;
		logic [15:0] edge_ctl;
		logic [15:0] stat;
		sirqc_fsm_t fsm;
		logic [3:0] cnt;
		logic [3:0] slot;
		logic pin_out;
		logic pin_oe;
		sirqc_rsp_t mem_rsp;
		sirqc_rsp_t cfg_rsp;
	} sirqc_state_t;

endpackage

/* bench/sirqc_periph.sv */
`timescale 1ns/1ns
module sirqc_periph (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_b_i,
	// device pin drive
	input wire logic dev_out_i,
	input wire logic dev_oe_i,
	// bench stimulus
	input wire logic [15:0] slot_mask_i,
	input wire logic req_frame_i,
	// resolved line, pulled up
	output logic line_o
);
	logic [3:0] run_r;
	logic [5:0] cnt_r;
	logic low;
	logic pull;
	assign low = dev_oe_i && !dev_out_i;
	// slot n above 0 low from two clocks before its sample clock, covers the sync delay
	assign pull = req_frame_i || (cnt_r > 6'h02 && cnt_r < 6'h30 && slot_mask_i[cnt_r / 3]);
	assign line_o = (dev_oe_i ? dev_out_i : 1'b1) && !pull;
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			run_r <= 4'h0;
			cnt_r <= 6'h3F;
		end else begin
			run_r <= low ? run_r + 4'h1 : 4'h0;
			// only a low run of 4 or more is a start, stop frames are shorter
			if (!low && run_r >= 4'h4)
				cnt_r <= 6'h01;
			else if (cnt_r != 6'h3F)
				cnt_r <= cnt_r + 6'h01;
		end
	end
endmodule

/* bench/serial_irq_controller_regs_bench.sv */
`timescale 1ns/1ns
module serial_irq_controller_regs_bench;
	import sirqc_pkg::*;
	logic clk_i = 1'b0;
	logic rst_b_i = 1'b0;
	logic perst_b_i = 1'b1;
	logic glob_rst = 1'b0;
	sirqc_req_t mreq = '0;
	sirqc_req_t creq = '0;
	sirqc_rsp_t mrsp;
	sirqc_rsp_t crsp;
	logic so;
	logic soe;
	logic line;
	logic [15:0] mask = 16'h0000;
	logic req = 1'b0;
	logic [15:0] rd;
	int mismatches = 0;
	int checked = 0;
	always #5 clk_i = ~clk_i;
	sirqc_top u_dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .perst_b_i(perst_b_i),
		.global_reset_input_i(glob_rst), .mem_req_i(mreq), .mem_rsp_o(mrsp),
		.cfg_req_i(creq), .cfg_rsp_o(crsp), .serirq_i(line), .serirq_o(so), .serirq_oe_o(soe));
	sirqc_periph u_periph (.clk_i(clk_i), .rst_b_i(rst_b_i), .dev_out_i(so), .dev_oe_i(soe),
		.slot_mask_i(mask), .req_frame_i(req), .line_o(line));
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			mismatches++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic complete_run;
		$display("checked=%0d mismatches=%0d", checked, mismatches);
		if (mismatches == 0 && checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic acc(input bit cfg, input bit wr, input logic [7:0] a, input logic [15:0] d);
		sirqc_req_t r;
		r = '{wr, !wr, a, 2'h3, d};
		@(posedge clk_i) #1;
		if (cfg)
			creq = r;
		else
			mreq = r;
		@(posedge clk_i) #1;
		creq = '0;
		mreq = '0;
		rd = cfg ? crsp.rdata : mrsp.rdata;
		chk({15'h0000, cfg ? crsp.ack : mrsp.ack}, 16'h0001);
	endtask
	task automatic rc(input bit cfg, input logic [7:0] a, input logic [15:0] e);
		acc(cfg, 0, a, 16'h0000);
		chk(rd, e);
	endtask
	task automatic oe_cnt(output int n);
		n = 0;
		repeat (80) begin
			@(posedge clk_i) #1;
			n += soe;
		end
	endtask
	task automatic wait_idle;
		int q = 0;
		// turnaround and slots keep the line released for 49 clocks, 50 with the drive bit set, so idle needs a longer quiet run
		for (int i = 0; i < 400 && q < 64; i++) begin
			@(posedge clk_i) #1;
			q = soe ? 0 : q + 1;
		end
		if (q < 64) begin
			mismatches++;
			complete_run;
		end
	endtask
	task automatic t_regs;
		acc(1, 1, SIRQC_MODE_CFG, 16'h00F3);
		rc(0, SIRQC_MODE_MEM, 16'h0003);
		acc(1, 1, SIRQC_EDGE_CFG, 16'hA5C3);
		rc(0, SIRQC_EDGE_MEM, 16'hA5C3);
		rc(0, 8'h50, 16'h0000);
		$display("regs done");
	endtask
	task automatic t_width;
		int len;
		for (int c = 0; c < 4; c++) begin
			acc(0, 1, SIRQC_MODE_MEM, 16'(c * 4 + 2 + (c == 3)));
			wait_idle;
			req = 1'b1;
			repeat (2) @(posedge clk_i) #1;
			req = 1'b0;
			len = 0;
			for (int i = 0; i < 20 && !(soe && !so); i++)
				@(posedge clk_i) #1;
			while (soe && !so && len < 20) begin
				len++;
				@(posedge clk_i) #1;
			end
			chk(16'(len), c == 1 ? 16'h0006 : c == 2 ? 16'h0008 : 16'h0004);
			chk({14'h0000, soe, so}, c == 3 ? 16'h0001 : 16'h0003);
		end
		$display("width done");
	endtask
	task automatic t_poll;
		int n;
		wait_idle;
		oe_cnt(n);
		chk(16'(n), 16'h0000);
		acc(0, 1, SIRQC_MODE_MEM, 16'h0000);
		rc(1, SIRQC_MODE_CFG, 16'h0000);
		oe_cnt(n);
		chk({15'h0000, n > 0}, 16'h0001);
		$display("poll done");
	endtask
	task automatic frames(input logic [15:0] m);
		mask = m;
		repeat (130) @(posedge clk_i) #1;
		mask = 16'h0000;
		repeat (70) @(posedge clk_i) #1;
	endtask
	task automatic t_level;
		acc(1, 1, SIRQC_EDGE_CFG, 16'h0208);
		frames(16'h0228);
		rc(0, SIRQC_STAT_MEM, 16'h0208);
		acc(0, 1, SIRQC_STAT_MEM, 16'h0000);
		rc(1, SIRQC_STAT_CFG, 16'h0208);
		acc(1, 1, SIRQC_STAT_CFG, 16'h0008);
		rc(0, SIRQC_STAT_MEM, 16'h0200);
		frames(16'h0008);
		rc(1, SIRQC_STAT_CFG, 16'h0208);
		$display("level done");
	endtask
	task automatic t_rst(input int k);
		logic [7:0] a[6] = '{SIRQC_MODE_MEM, SIRQC_EDGE_MEM, SIRQC_STAT_MEM,
			SIRQC_MODE_CFG, SIRQC_EDGE_CFG, SIRQC_STAT_CFG};
		acc(0, 1, SIRQC_EDGE_MEM, 16'hFFFF);
		acc(0, 1, SIRQC_MODE_MEM, 16'h000D);
		if (k == 1)
			glob_rst = 1'b1;
		else if (k == 2)
			perst_b_i = 1'b0;
		else
			rst_b_i = 1'b0;
		repeat (4) @(posedge clk_i) #1;
		glob_rst = 1'b0;
		perst_b_i = 1'b1;
		rst_b_i = 1'b1;
		repeat (3) @(posedge clk_i) #1;
		for (int i = 0; i < 6; i++)
			rc(i > 2, a[i], 16'h0000);
		$display("reset %0d done", k);
	endtask
	initial begin
		repeat (8) @(posedge clk_i);
		#1 rst_b_i = 1'b1;
		t_regs;
		t_width;
		t_poll;
		t_level;
		for (int k = 1; k < 4; k++)
			t_rst(k % 3);
		complete_run;
	end
endmodule
